// file: pkg/std_timer_consts.vh
`ifndef STD_TIMER_CONSTS_VH
`define STD_TIMER_CONSTS_VH
// register byte addresses on the apb bus
`define ADDR_CTRL0      12'h000
`define ADDR_MODE_CTRL  12'h004
`define ADDR_CNT_LO     12'h008
`define ADDR_CNT_HI     12'h00C
`define ADDR_CMPA_LO    12'h010
`define ADDR_CMPA_HI    12'h014
// control register 0 fields
`define C0_ON_BIT       3
`define C0_RP_LSB       0
// mode control fields
`define MC_MODE_LSB     6
`define MC_FUNC_LSB     4
`define MC_OC_BIT       3
`define MC_POL_BIT      2
`define MC_DPX_BIT      1
`define MC_CCLR_BIT     0
// operating modes
`define MODE_COMPARE    2'h0
`define MODE_CAPTURE    2'h1
`define MODE_PWM        2'h2
`define MODE_TIMER      2'h3
// reset values
`define RST_BYTE        8'h00
`define RST_CNT         10'h000
`endif

// file: verif/cap_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module cap_pin_model (
  // clock and pin
  input  wire logic clk,
  output var  logic capture_input_pin
);
  initial capture_input_pin = 1'b0;
  // edge launched after a clock edge; the block must resynchronise it
  task drive(input logic v);
    @(posedge clk) capture_input_pin <= v;
  endtask
endmodule // cap_pin_model
`default_nettype wire

// file: verif/std_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "std_timer_consts.vh"
module std_timer_chk (
  // bus and pins
  input wire logic        clk, rst, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        timer_out_en, capture_event
);
  logic [7:0] mc_q;
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  // shadow of the mode byte, so pin checks know the mode
  always @(posedge clk)
    if (rst) mc_q <= 8'h00;
    else if (acc && pwrite && paddr == `ADDR_MODE_CTRL) mc_q <= pwdata[7:0];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ready_high_a: assert property (!rd |-> pready) else $error("pready low outside a read");
  read_wait_a: assert property (rd && !pready |=> pready) else $error("read not answered");
  bad_addr_a: assert property (acc && paddr > 12'h014 |-> pslverr) else $error("no slverr");
  good_addr_a: assert property (acc && paddr <= 12'h014 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("false slverr");
  bad_read_a: assert property (rd && paddr > 12'h014 |=> prdata == 32'h0) else $error("bad data");
  cnt_hi_a: assert property (rd && paddr == `ADDR_CNT_HI |=> prdata[31:2] == 30'h0)
    else $error("counter high byte spare bits");
  cmpa_hi_a: assert property (rd && paddr == `ADDR_CMPA_HI |=> prdata[31:2] == 30'h0)
    else $error("compare high byte spare bits");
  timer_pin_a: assert property (mc_q[7:6] == `MODE_TIMER && $past(mc_q[7:6], 2) == `MODE_TIMER
    |-> !timer_out_en) else $error("pin driven in timer mode");
  cap_pin_a: assert property (mc_q[7:6] == `MODE_CAPTURE && $past(mc_q[7:6], 2) == `MODE_CAPTURE
    |-> !timer_out_en) else $error("pin driven in capture mode");
  cap_off_a: assert property (mc_q[7:4] == 4'h7 && $past(mc_q[7:4], 5) == 4'h7 |-> !capture_event)
    else $error("capture while disabled");
  cap_pulse_a: assert property (capture_event |=> !capture_event) else $error("long capture");
endmodule // std_timer_chk
bind std_timer std_timer_chk u_std_timer_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .timer_out_en(timer_out_en), .capture_event(capture_event));
`default_nettype wire

// file: verif/tb_std_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "std_timer_consts.vh"
module tb_std_timer;
  logic        clk, rst, psel, penable, pwrite, timer_tick, pready, pslverr;
  logic        timer_out, timer_out_en, match_a, match_p, cap_ev, cap_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [9:0]  cap_val;
  logic [7:0]  pm [7] = '{8'h18, 8'h28, 8'h08, 8'h30, 8'h1C, 8'h88, 8'h98};
  logic [1:0]  pe [7] = '{2'b10, 2'b11, 2'b11, 2'b01, 2'b01, 2'b00, 2'b11};
  integer      miscompares, checked, cyc, i, j, n, ma_n, mp_n;
  std_timer u_std_timer (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer_tick(timer_tick), .capture_input_pin(cap_pin), .timer_out(timer_out),
    .timer_out_en(timer_out_en), .match_a(match_a), .match_p(match_p),
    .capture_event(cap_ev), .capture_value(cap_val));
  cap_pin_model u_cap_pin_model (.clk(clk), .capture_input_pin(cap_pin));
  // comparator pulses counted for the clear-source checks
  always @(posedge clk) begin
    mp_n <= mp_n + (match_p === 1'b1);
    ma_n <= ma_n + (match_a === 1'b1);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at an edge; read data taken there
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rpair(input logic [11:0] hi);
    apb(0, hi, 32'h0);
    n = r;
    apb(0, hi - 12'h004, 32'h0);
    r = {22'h0, n[1:0], r[7:0]};
  endtask
  task tick(input integer k);
    repeat (k) begin
      timer_tick <= 1;
      @(posedge clk);
    end
    timer_tick <= 0;
  endtask
  // mode and function only changed while the timer is off
  task run(input logic [7:0] mc, input logic [2:0] p, input integer k);
    wr(`ADDR_CTRL0, 32'h0);
    wr(`ADDR_MODE_CTRL, {24'h0, mc});
    wr(`ADDR_CTRL0, {28'h0, 1'b1, p});
    tick(k);
    wr(`ADDR_CTRL0, {29'h0, p});
    tick(10);
    rpair(`ADDR_CNT_HI);
  endtask
  task t_regs;
    for (i = 4; i <= 32; i += 4) begin
      apb(0, i[11:0], 32'h0);
      chk(r, 32'h0);
    end
    wr(`ADDR_CNT_LO, 32'hFF);
    rpair(`ADDR_CNT_HI);
    chk(r, 32'h0);
    wr(`ADDR_MODE_CTRL, 32'hFF);
    apb(0, `ADDR_MODE_CTRL, 32'h0);
    chk(r, 32'hFF);
    $display("t_regs done");
  endtask
  task t_cmpa;
    wr(`ADDR_CMPA_LO, 32'hA5);
    rpair(`ADDR_CMPA_HI);
    chk(r, 32'h0);
    wr(`ADDR_CMPA_LO, 32'hA5);
    wr(`ADDR_CMPA_HI, 32'h3);
    rpair(`ADDR_CMPA_HI);
    chk(r, 32'h3A5);
    $display("t_cmpa done");
  endtask
  task t_count;
    for (i = 0; i < 8; i++) begin
      j = mp_n;
      run(8'h00, i[2:0], (i == 0 ? 1024 : 128 * i) + 3);
      chk(r, 32'h3);
      chk(mp_n - j, 1);
    end
    wr(`ADDR_CMPA_LO, 32'h64);
    wr(`ADDR_CMPA_HI, 32'h0);
    j = ma_n;
    run(8'h01, 3'h1, 150);
    chk(r, 32'h31);
    chk(ma_n - j, 1);
    run(8'h81, 3'h1, 150);
    chk(r, 32'h16);
    run(8'h83, 3'h1, 150);
    chk(r, 32'h31);
    $display("t_count done");
  endtask
  task t_pin;
    wr(`ADDR_CMPA_LO, 32'h5);
    wr(`ADDR_CMPA_HI, 32'h0);
    for (i = 0; i < 7; i++) begin
      wr(`ADDR_CTRL0, 32'h0);
      wr(`ADDR_MODE_CTRL, {24'h0, pm[i]});
      wr(`ADDR_CTRL0, 32'h8);
      @(posedge clk);
      @(negedge clk) chk(timer_out, pe[i][1]);
      @(posedge clk) tick(10);
      @(negedge clk) chk(timer_out, pe[i][0]);
      @(posedge clk);
    end
    $display("t_pin done");
  endtask
  task t_cap;
    for (i = 0; i < 4; i++) begin
      wr(`ADDR_CTRL0, 32'h0);
      wr(`ADDR_MODE_CTRL, 32'h40 + 32'h10 * i);
      wr(`ADDR_CTRL0, 32'h8);
      tick(5 + i);
      u_cap_pin_model.drive(!cap_pin);
      n = 0;
      for (j = 0; j < 8; j++) @(negedge clk) n += (cap_ev === 1'b1);
      @(posedge clk);
      chk(n, i < 3);
      chk({22'h0, cap_val}, i < 3 ? 5 + i : 7);
    end
    $display("t_cap done");
  endtask
  task tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    cyc = 0;
    forever @(posedge clk) if (++cyc > 40000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    {psel, penable, pwrite, timer_tick, paddr, pwdata} = '0;
    {miscompares, checked, ma_n, mp_n} = '0;
    rst = 1;
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs;
    t_cmpa;
    t_count;
    t_pin;
    t_cap;
    tally_and_finish;
  end
endmodule // tb_std_timer
`default_nettype wire

// file: verilog/std_timer.v
// How it works
// R1 - period bits compare counter bits nine to seven
// R2 - period zero means 1024, else 128 * value steps
// R3 - clear select 0: period match or overflow
// R4 - clear select 1: clear on compare a
// R5 - clear select ignored in pwm, pulse, capture
// R6 - mode field picks compare, capture, pwm, timer
// R7 - software stops timer before changing mode
// R8 - timer mode: pin settings have no effect
// R9 - compare match: hold, low, high, toggle
// R10 - pwm codes: inactive, active, pwm, pulse
// R11 - capture: rising, falling, both, disabled
// R12 - requested equals initial level: no change
// R13 - counter on rising restores initial level
// R14 - software changes pwm function only stopped
// R15 - output control sets initial pin level
// R16 - output control sets pwm/pulse active level
// R17 - polarity bit inverts output pin
// R18 - swap bit exchanges period and duty
// R19 - counter readable as low/high bytes
// R20 - compare a held in byte pair
// R21 - low write buffered, high write commits
// R22 - high read latches low byte into buffer
// R23 - on rising clears, falling holds count
`timescale 1ns/1ps
`default_nettype none
`include "std_timer_consts.vh"
module std_timer #(
  parameter CNT_W = 10
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // timer clock tick from clock selection
  input  wire        timer_tick,
  // pins
  input  wire        capture_input_pin,
  output reg         timer_out,
  output reg         timer_out_en,
  // events
  output reg         match_a,
  output reg         match_p,
  output reg         capture_event,
  output reg  [9:0]  capture_value
);
  reg  [7:0]  ctrl0_q;
  reg  [7:0]  mode_ctrl_q;
  reg  [9:0]  cmpa_q;
  reg  [7:0]  buf_q;
  reg  [9:0]  count_q;
  reg         on_prev_q;
  reg         pin_q;
  reg         cap_s1_q;
  reg         cap_s2_q;
  reg         cap_prev_q;
  reg         rdv_q;
  wire        wr = psel & penable & pwrite;
  wire        rd = psel & penable & ~pwrite;
  wire        rd_go = rd & ~rdv_q;
  wire        on_bit = ctrl0_q[`C0_ON_BIT];
  wire [2:0]  rp = ctrl0_q[`C0_RP_LSB +: 3];
  wire [1:0]  mode = mode_ctrl_q[`MC_MODE_LSB +: 2];
  wire [1:0]  func = mode_ctrl_q[`MC_FUNC_LSB +: 2];
  wire        oc = mode_ctrl_q[`MC_OC_BIT];
  wire        pol = mode_ctrl_q[`MC_POL_BIT];
  wire        dpx = mode_ctrl_q[`MC_DPX_BIT];
  wire        cclr = mode_ctrl_q[`MC_CCLR_BIT];
  wire        on_rise = on_bit & ~on_prev_q;
  wire        known = (paddr == `ADDR_CTRL0) | (paddr == `ADDR_MODE_CTRL) |
                      (paddr == `ADDR_CNT_LO) | (paddr == `ADDR_CNT_HI) |
                      (paddr == `ADDR_CMPA_LO) | (paddr == `ADDR_CMPA_HI);
  // R1 top three bits; last count before 128 * value ends the period
  wire [2:0]  rp_m1 = rp - 3'h1;
  wire        p_hit = (count_q[9:7] == rp_m1) & (count_q[6:0] == 7'h7F);
  wire        ovf = (count_q == 10'h3FF);
  wire        a_hit = (count_q == cmpa_q);
  // R2 zero means overflow
  wire        p_match = (rp == 3'h0) ? ovf : p_hit;
  wire        run = on_bit & timer_tick;
  // R18 period/duty roles
  wire        pwm_end = dpx ? a_hit : p_match;
  wire [9:0]  duty_cnt = dpx ? {rp, 7'h00} : cmpa_q;
  wire        pwm_full = dpx ? (rp == 3'h0) : 1'b0;
  wire        pwm_act = pwm_full | (count_q < duty_cnt) |
                        (~dpx & (cmpa_q >= {rp, 7'h00}) & (rp != 3'h0));
  reg         clr;
  reg         out_lvl;
  // one wait state on reads, so registered read data stands at the ready edge
  assign pready = ~rd | rdv_q;
  assign pslverr = psel & penable & ~known;
  always @* begin
    clr = 1'b0;
    case (mode)
      // R5 pwm ignores clear select
      `MODE_PWM: clr = (func == 2'h3) ? 1'b0 : pwm_end;
      `MODE_CAPTURE: clr = ovf;
      // R3 R4 clear source
      default: clr = cclr ? a_hit : (p_match | ovf);
    endcase
  end
  // R19 R22 read path
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      rdv_q <= 1'b0;
    end else begin
      rdv_q <= rd_go;
      if (rd_go) begin
        case (paddr)
          `ADDR_CTRL0: prdata <= {24'h000000, ctrl0_q};
          `ADDR_MODE_CTRL: prdata <= {24'h000000, mode_ctrl_q};
          `ADDR_CNT_HI: prdata <= {30'h0, count_q[9:8]};
          `ADDR_CMPA_HI: prdata <= {30'h0, cmpa_q[9:8]};
          `ADDR_CNT_LO: prdata <= {24'h000000, buf_q};
          `ADDR_CMPA_LO: prdata <= {24'h000000, buf_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // register writes and shared buffer
  always @(posedge clk) begin
    if (rst) begin
      ctrl0_q <= `RST_BYTE;
      mode_ctrl_q <= `RST_BYTE;
      cmpa_q <= `RST_CNT;
      buf_q <= `RST_BYTE;
    end else begin
      if (wr & (paddr == `ADDR_CTRL0)) begin
        ctrl0_q <= pwdata[7:0];
      end
      if (wr & (paddr == `ADDR_MODE_CTRL)) begin
        mode_ctrl_q <= pwdata[7:0];
      end
      // R20 R21 buffer then commit
      if (wr & (paddr == `ADDR_CMPA_LO)) begin
        buf_q <= pwdata[7:0];
      end
      if (wr & (paddr == `ADDR_CMPA_HI)) begin
        cmpa_q <= {pwdata[1:0], buf_q};
      end
      // R22 latch low on high read
      if (rd_go & (paddr == `ADDR_CNT_HI)) begin
        buf_q <= count_q[7:0];
      end
      if (rd_go & (paddr == `ADDR_CMPA_HI)) begin
        buf_q <= cmpa_q[7:0];
      end
      // single pulse ends on compare a
      if (mode == `MODE_PWM && func == 2'h3 && on_bit && run && a_hit) begin
        ctrl0_q[`C0_ON_BIT] <= 1'b0;
      end
    end
  end
  // counter
  always @(posedge clk) begin
    if (rst) begin
      count_q <= `RST_CNT;
      on_prev_q <= 1'b0;
      match_a <= 1'b0;
      match_p <= 1'b0;
    end else begin
      on_prev_q <= on_bit;
      match_a <= run & a_hit & ~(mode != `MODE_PWM && cmpa_q == 10'h000);
      match_p <= run & p_match & ~(cclr & mode != `MODE_PWM);
      // R23 on edge clears
      if (on_rise) begin
        count_q <= `RST_CNT;
      end else if (run) begin
        count_q <= clr ? `RST_CNT : count_q + 10'h001;
      end
    end
  end
  // capture synchroniser, edge detect on second stage only
  always @(posedge clk) begin
    if (rst) begin
      cap_s1_q <= 1'b0;
      cap_s2_q <= 1'b0;
      cap_prev_q <= 1'b0;
      capture_event <= 1'b0;
      capture_value <= `RST_CNT;
    end else begin
      cap_s1_q <= capture_input_pin;
      cap_s2_q <= cap_s1_q;
      cap_prev_q <= cap_s2_q;
      capture_event <= 1'b0;
      // R11 capture edge select
      if (mode == `MODE_CAPTURE && on_bit &&
          ((func == 2'h0 && cap_s2_q && !cap_prev_q) ||
           (func == 2'h1 && !cap_s2_q && cap_prev_q) ||
           (func == 2'h2 && cap_s2_q != cap_prev_q))) begin
        capture_event <= 1'b1;
        capture_value <= count_q;
      end
    end
  end
  // compare output level
  always @(posedge clk) begin
    if (rst) begin
      pin_q <= 1'b0;
    end else if (on_rise) begin
      // R13 R15 restore initial level
      pin_q <= oc;
    end else if (mode == `MODE_COMPARE && run && a_hit && cmpa_q != 10'h000) begin
      // R9 R12 same level gives no change
      case (func)
        2'h1: pin_q <= 1'b0;
        2'h2: pin_q <= 1'b1;
        2'h3: pin_q <= ~pin_q;
        default: pin_q <= pin_q;
      endcase
    end else if (mode == `MODE_PWM && func == 2'h3 && on_prev_q && !on_bit) begin
      pin_q <= ~oc;
    end
  end
  // R6 R10 R16 mode output select
  always @* begin
    out_lvl = pin_q;
    case (mode)
      `MODE_PWM: begin
        case (func)
          2'h0: out_lvl = ~oc;
          2'h1: out_lvl = oc;
          2'h2: out_lvl = (on_bit & pwm_act) ? oc : ~oc;
          default: out_lvl = on_bit ? oc : ~oc;
        endcase
      end
      default: out_lvl = pin_q;
    endcase
  end
  // pin driver: data registered
  always @(posedge clk) begin
    if (rst) begin
      timer_out <= 1'b0;
      timer_out_en <= 1'b0;
    end else begin
      // R17 polarity invert
      timer_out <= out_lvl ^ pol;
      // R8 timer mode leaves pin undriven
      timer_out_en <= (mode == `MODE_COMPARE) | (mode == `MODE_PWM);
    end
  end
endmodule // std_timer
`default_nettype wire
